// ==== design/rtc_cmos_ram.sv ====
module rtc_cmos_ram #(
  parameter int CLK_HZ = rtc_pkg::CLK_HZ,
  parameter int TB_HZ  = rtc_pkg::TB_HZ
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic [15:0] IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  input  wire logic        POWER_GOOD,
  output logic [7:0]       IO_RDATA,
  output logic             NMI_DISABLE,
  output logic             IRQ,
  output logic             SQW_OUT
);

  logic [7:0]          ram_q [0:rtc_pkg::RAM_BYTES-1];
  logic [5:0]          index_q;
  logic                nmi_mask_q;
  logic [2:0]          dv_q;
  logic [3:0]          rs_q;
  logic [7:0]          b_q;
  logic                pf_q;
  logic                af_q;
  logic                uf_q;
  logic [31:0]         acc_q;
  logic [14:0]         div_q;
  rtc_pkg::upd_state_t st_q;
  logic [3:0]          uip_cnt_q;
  logic                dst_done_q;
  logic [7:0]          rdata_q;
  logic                sqw_q;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    to_bin = bin ? v : 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] from_bin(input logic [7:0] n, input logic bin);
    from_bin = bin ? n : {4'(n / 8'd10), 4'(n % 8'd10)};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'd2:                      month_days = (y[1:0] == 2'h0) ? 8'd29 : 8'd28;
      8'd4, 8'd6, 8'd9, 8'd11:   month_days = 8'd30;
      default:                   month_days = 8'd31;
    endcase
  endfunction

  function automatic logic [3:0] period_log2(input logic [3:0] rs);
    case (rs)
      4'h1:    period_log2 = 4'h7;
      4'h2:    period_log2 = 4'h8;
      default: period_log2 = rs - 4'h1;
    endcase
  endfunction

  function automatic logic alarm_hit(input logic [7:0] alm, input logic [7:0] v);
    alarm_hit = (alm[7:6] == rtc_pkg::ALM_ANY) || (alm == v);
  endfunction

  // ----------------------------------------
  // Host port decode
  // ----------------------------------------
  logic idx_wr;
  logic data_wr;
  logic data_rd;
  logic clk_loc;
  assign idx_wr  = IO_WR && (IO_ADDR == rtc_pkg::INDEX_PORT);
  assign data_wr = IO_WR && (IO_ADDR == rtc_pkg::DATA_PORT);
  assign data_rd = IO_RD && (IO_ADDR == rtc_pkg::DATA_PORT);
  assign clk_loc = (index_q >= rtc_pkg::LOC_REG_A) && (index_q <= rtc_pkg::LOC_REG_D);

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      index_q    <= rtc_pkg::LOC_REG_D;
      nmi_mask_q <= 1'b1;
    end
    else if (idx_wr)
    begin
      index_q    <= IO_WDATA[5:0];
      nmi_mask_q <= IO_WDATA[rtc_pkg::IDX_NMI];
    end
  end
  assign NMI_DISABLE = nmi_mask_q;

  // ----------------------------------------
  // Time base and divider chain
  // ----------------------------------------
  logic [31:0] acc_sum;
  logic        tb_tick;
  logic        dv_ok;
  logic        sec_tick;
  logic        per_tick;
  logic [3:0]  per_sel;
  logic [14:0] per_mask;
  assign acc_sum  = acc_q + 32'(TB_HZ);
  assign tb_tick  = (acc_sum >= 32'(CLK_HZ));
  assign dv_ok    = (dv_q == rtc_pkg::DV_32K);
  assign sec_tick = tb_tick && dv_ok && (div_q == 15'h7fff);
  assign per_sel  = period_log2(rs_q);
  assign per_mask = 15'((16'h1 << per_sel) - 16'h1);
  assign per_tick = tb_tick && dv_ok && (rs_q != 4'h0) && ((div_q & per_mask) == per_mask);

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      acc_q <= 32'h0;
    else if (tb_tick)
      acc_q <= acc_sum - 32'(CLK_HZ);
    else
      acc_q <= acc_sum;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST || !dv_ok)
      div_q <= 15'h0;
    else if (tb_tick)
      div_q <= div_q + 15'h1;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      sqw_q <= 1'b0;
    else
      sqw_q <= b_q[rtc_pkg::B_SQWE] && dv_ok && (rs_q != 4'h0)
               && div_q[per_sel - 4'h1];
  end
  assign SQW_OUT = sqw_q;

  // ----------------------------------------
  // Update cycle sequencer
  // ----------------------------------------
  logic uip;
  assign uip = (st_q != rtc_pkg::UPD_IDLE);

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      st_q      <= rtc_pkg::UPD_IDLE;
      uip_cnt_q <= 4'h0;
    end
    else
    begin
      case (st_q)
        rtc_pkg::UPD_IDLE:
          if (sec_tick && !b_q[rtc_pkg::B_SET])
          begin
            st_q      <= rtc_pkg::UPD_WAIT;
            uip_cnt_q <= 4'h0;
          end
        rtc_pkg::UPD_WAIT:
          if (b_q[rtc_pkg::B_SET])
            st_q <= rtc_pkg::UPD_IDLE;
          else if (tb_tick)
          begin
            uip_cnt_q <= uip_cnt_q + 4'h1;
            if (uip_cnt_q == 4'(rtc_pkg::UIP_TICKS - 1))
              st_q <= rtc_pkg::UPD_APPLY;
          end
        rtc_pkg::UPD_APPLY:
          st_q <= rtc_pkg::UPD_IDLE;
        default:
          st_q <= rtc_pkg::UPD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Next time and calendar
  // ----------------------------------------
  logic       bm;
  logic [7:0] s, m, h, h12, wd, md, mo, yr;
  logic [7:0] ns, nm, nh, nwd, nmd, nmo, nyr, no12;
  logic [7:0] o_sec, o_min, o_hr;
  logic       dst_fall;
  logic       alm_match;

  always_comb
  begin
    bm  = b_q[rtc_pkg::B_BIN];
    s   = to_bin(ram_q[rtc_pkg::LOC_SEC], bm);
    m   = to_bin(ram_q[rtc_pkg::LOC_MIN], bm);
    wd  = to_bin(ram_q[rtc_pkg::LOC_WDAY], bm);
    md  = to_bin(ram_q[rtc_pkg::LOC_MDAY], bm);
    mo  = to_bin(ram_q[rtc_pkg::LOC_MON], bm);
    yr  = to_bin(ram_q[rtc_pkg::LOC_YEAR], bm);
    h12 = to_bin({1'b0, ram_q[rtc_pkg::LOC_HR][6:0]}, bm);
    if (b_q[rtc_pkg::B_24H])
      h = to_bin(ram_q[rtc_pkg::LOC_HR], bm);
    else
      h = ((h12 == 8'd12) ? 8'd0 : h12) + (ram_q[rtc_pkg::LOC_HR][7] ? 8'd12 : 8'd0);
    ns  = s + 8'd1;
    nm  = m;
    nh  = h;
    nwd = wd;
    nmd = md;
    nmo = mo;
    nyr = yr;
    if (ns >= 8'd60)
    begin
      ns = 8'd0;
      nm = m + 8'd1;
    end
    if (nm >= 8'd60)
    begin
      nm = 8'd0;
      nh = h + 8'd1;
    end
    if (nh >= 8'd24)
    begin
      nh  = 8'd0;
      nwd = (wd >= 8'd7) ? 8'd1 : wd + 8'd1;
      nmd = md + 8'd1;
      if (nmd > month_days(mo, yr))
      begin
        nmd = 8'd1;
        nmo = mo + 8'd1;
      end
      if (nmo > 8'd12)
      begin
        nmo = 8'd1;
        nyr = (yr >= 8'd99) ? 8'd0 : yr + 8'd1;
      end
    end
    dst_fall = 1'b0;
    if (b_q[rtc_pkg::B_DSE] && wd == 8'd1 && h == 8'd1 && m == 8'd59 && s == 8'd59)
    begin
      if (mo == 8'd4 && md >= 8'd24)
        nh = 8'd3;
      else if (mo == 8'd10 && md >= 8'd25 && !dst_done_q)
      begin
        nh       = 8'd1;
        dst_fall = 1'b1;
      end
    end
    no12  = (nh % 8'd12 == 8'd0) ? 8'd12 : nh % 8'd12;
    o_sec = from_bin(ns, bm);
    o_min = from_bin(nm, bm);
    if (b_q[rtc_pkg::B_24H])
      o_hr = from_bin(nh, bm);
    else
      o_hr = {nh >= 8'd12, 7'(from_bin(no12, bm))};
    alm_match = alarm_hit(ram_q[rtc_pkg::LOC_SEC_ALM], o_sec)
             && alarm_hit(ram_q[rtc_pkg::LOC_MIN_ALM], o_min)
             && alarm_hit(ram_q[rtc_pkg::LOC_HR_ALM], o_hr);
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      dst_done_q <= 1'b0;
    else if (st_q == rtc_pkg::UPD_APPLY)
    begin
      if (dst_fall)
        dst_done_q <= 1'b1;
      else if (nh == 8'd3)
        dst_done_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Byte array
  // ----------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (st_q == rtc_pkg::UPD_APPLY)
    begin
      ram_q[rtc_pkg::LOC_SEC]  <= o_sec;
      ram_q[rtc_pkg::LOC_MIN]  <= o_min;
      ram_q[rtc_pkg::LOC_HR]   <= o_hr;
      ram_q[rtc_pkg::LOC_WDAY] <= from_bin(nwd, bm);
      ram_q[rtc_pkg::LOC_MDAY] <= from_bin(nmd, bm);
      ram_q[rtc_pkg::LOC_MON]  <= from_bin(nmo, bm);
      ram_q[rtc_pkg::LOC_YEAR] <= from_bin(nyr, bm);
    end
    if (data_wr && !clk_loc)
      ram_q[index_q] <= IO_WDATA;
  end

  // ----------------------------------------
  // Status A and B
  // ----------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      dv_q <= rtc_pkg::DV_RESET;
      rs_q <= rtc_pkg::RS_RESET;
      b_q  <= rtc_pkg::B_RESET;
    end
    else if (data_wr && index_q == rtc_pkg::LOC_REG_A)
    begin
      dv_q <= IO_WDATA[6:4];
      rs_q <= IO_WDATA[3:0];
    end
    else if (data_wr && index_q == rtc_pkg::LOC_REG_B)
      b_q <= IO_WDATA;
  end

  // ----------------------------------------
  // Status C flags and interrupt
  // ----------------------------------------
  logic c_rd;
  logic irqf;
  logic upd_done;
  assign c_rd     = data_rd && (index_q == rtc_pkg::LOC_REG_C);
  assign upd_done = (st_q == rtc_pkg::UPD_APPLY);

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pf_q <= 1'b0;
      af_q <= 1'b0;
      uf_q <= 1'b0;
    end
    else
    begin
      pf_q <= per_tick || (pf_q && !c_rd);
      af_q <= (upd_done && alm_match) || (af_q && !c_rd);
      uf_q <= upd_done || (uf_q && !c_rd);
    end
  end

  assign irqf = (pf_q && b_q[rtc_pkg::B_PIE])
             || (af_q && b_q[rtc_pkg::B_AIE])
             || (uf_q && b_q[rtc_pkg::B_UIE]);
  assign IRQ = irqf;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      rdata_q <= 8'h00;
    else if (data_rd)
    begin
      case (index_q)
        rtc_pkg::LOC_REG_A: rdata_q <= {uip, dv_q, rs_q};
        rtc_pkg::LOC_REG_B: rdata_q <= b_q;
        rtc_pkg::LOC_REG_C: rdata_q <= {irqf, pf_q, af_q, uf_q, 4'h0};
        rtc_pkg::LOC_REG_D: rdata_q <= {POWER_GOOD, 7'h00};
        default:            rdata_q <= ram_q[index_q];
      endcase
    end
  end
  assign IO_RDATA = rdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_nmi_mask_write: assert property (idx_wr |=> NMI_DISABLE == $past(IO_WDATA[7]))
    else $error("NMI mask not taken from index write");
  a_index_select: assert property (idx_wr |=> index_q == $past(IO_WDATA[5:0]))
    else $error("index not taken from index write");
  a_ram_readback: assert property ((data_wr && index_q >= 6'd14) ##2 (data_rd && $stable(index_q)) |=> IO_RDATA == $past(IO_WDATA, 3))
    else $error("storage byte read back wrong");
  a_uip_read: assert property ((data_rd && index_q == rtc_pkg::LOC_REG_A) |=> IO_RDATA[7] == $past(uip))
    else $error("update flag misreported");
  a_set_holds: assert property (b_q[rtc_pkg::B_SET] && st_q != rtc_pkg::UPD_APPLY |=> st_q == rtc_pkg::UPD_IDLE)
    else $error("update ran while set bit high");
  a_uf_after_update: assert property (upd_done |=> uf_q && !uip)
    else $error("update-ended flag missing");
  a_irq_needs_flag: assert property (!(pf_q || af_q || uf_q) |-> !IRQ)
    else $error("interrupt with no flag");
  a_irq_uf_enabled: assert property (uf_q && b_q[rtc_pkg::B_UIE] |-> IRQ)
    else $error("enabled update flag gave no interrupt");
  a_read_clears: assert property (c_rd && !per_tick && !upd_done |=> !pf_q && !uf_q && !af_q)
    else $error("status C read did not clear flags");
  a_power_flag: assert property ((data_rd && index_q == rtc_pkg::LOC_REG_D) |=> IO_RDATA == {$past(POWER_GOOD), 7'h00})
    else $error("status D wrong");
  a_sqw_off: assert property (!b_q[rtc_pkg::B_SQWE] |=> !SQW_OUT)
    else $error("square wave while disabled");
  a_divider_hold: assert property (!dv_ok |=> div_q == 15'h0)
    else $error("divider ran with bad select");

  c_update_done: cover property (upd_done);
  c_alarm_flag:  cover property (upd_done && alm_match);
  c_periodic:    cover property (per_tick && b_q[rtc_pkg::B_PIE]);
  c_clear_read:  cover property (c_rd && IRQ);

endmodule // rtc_cmos_ram

// ==== design/rtc_pkg.sv ====
package rtc_pkg;

  // ----------------------------------------
  // Host ports and array size
  // ----------------------------------------
  localparam logic [15:0] INDEX_PORT  = 16'h0070;
  localparam logic [15:0] DATA_PORT   = 16'h0071;
  localparam int          RAM_BYTES   = 64;
  localparam int          CLOCK_BYTES = 14;

  // ----------------------------------------
  // Byte locations
  // ----------------------------------------
  localparam logic [5:0] LOC_SEC     = 6'h00;
  localparam logic [5:0] LOC_SEC_ALM = 6'h01;
  localparam logic [5:0] LOC_MIN     = 6'h02;
  localparam logic [5:0] LOC_MIN_ALM = 6'h03;
  localparam logic [5:0] LOC_HR      = 6'h04;
  localparam logic [5:0] LOC_HR_ALM  = 6'h05;
  localparam logic [5:0] LOC_WDAY    = 6'h06;
  localparam logic [5:0] LOC_MDAY    = 6'h07;
  localparam logic [5:0] LOC_MON     = 6'h08;
  localparam logic [5:0] LOC_YEAR    = 6'h09;
  localparam logic [5:0] LOC_REG_A   = 6'h0a;
  localparam logic [5:0] LOC_REG_B   = 6'h0b;
  localparam logic [5:0] LOC_REG_C   = 6'h0c;
  localparam logic [5:0] LOC_REG_D   = 6'h0d;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IDX_NMI  = 7;
  localparam int B_SET    = 7;
  localparam int B_PIE    = 6;
  localparam int B_AIE    = 5;
  localparam int B_UIE    = 4;
  localparam int B_SQWE   = 3;
  localparam int B_BIN    = 2;
  localparam int B_24H    = 1;
  localparam int B_DSE    = 0;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [2:0] DV_32K      = 3'h2;
  localparam logic [2:0] DV_RESET    = 3'h2;
  localparam logic [3:0] RS_RESET    = 4'h6;
  localparam logic [7:0] B_RESET     = 8'h02;
  localparam logic [1:0] ALM_ANY     = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ      = 200_000_000;
  localparam int TB_HZ       = 32768;
  localparam int UIP_LEAD_US = 244;
  localparam int UIP_TICKS   = (UIP_LEAD_US * TB_HZ + 999_999) / 1_000_000;

  typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT, UPD_APPLY} upd_state_t;

endpackage

// ==== dv/rtc_host_model.sv ====
module rtc_host_model (
  input  wire logic        MCLK,
  output logic [15:0]      IO_ADDR,
  output logic             IO_WR,
  output logic             IO_RD,
  output logic [7:0]       IO_WDATA,
  input  wire logic [7:0]  IO_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Host port cycles
  // ----------------------------------------
  initial
  begin
    IO_ADDR  = 16'hffff;
    IO_WR    = 1'b0;
    IO_RD    = 1'b0;
    IO_WDATA = 8'h00;
  end

  // One strobe cycle; afterwards strobes drop low and address and data show the inverse of the last value
  task automatic io_cycle(input logic [15:0] addr, input logic wr, input logic [7:0] data);
    @(posedge MCLK);
    IO_ADDR  <= addr;
    IO_WR    <= wr;
    IO_RD    <= ~wr;
    IO_WDATA <= data;
    @(posedge MCLK);
    IO_ADDR  <= ~addr;
    IO_WR    <= 1'b0;
    IO_RD    <= 1'b0;
    IO_WDATA <= ~data;
  endtask

  // Index write, then straight away the data write
  task automatic put_byte(input logic [7:0] idx, input logic [7:0] data);
    io_cycle(rtc_pkg::INDEX_PORT, 1'b1, idx);
    io_cycle(rtc_pkg::DATA_PORT, 1'b1, data);
  endtask

  // Index write, then straight away the data read
  task automatic get_byte(input logic [7:0] idx, output logic [7:0] data);
    io_cycle(rtc_pkg::INDEX_PORT, 1'b1, idx);
    io_cycle(rtc_pkg::DATA_PORT, 1'b0, 8'h00);
    @(posedge MCLK);
    #1;
    data = IO_RDATA;
  endtask

  // Leaves the index on status D with the NMI masked
  task automatic park(output logic [7:0] data);
    get_byte(8'h8d, data);
  endtask
endmodule // rtc_host_model

// ==== dv/test_rtc_cmos_ram.sv ====
module test_rtc_cmos_ram;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SIM_CLK_HZ = 65536;
  localparam int SIM_TB_HZ  = 32768;
  localparam int CYC_LIMIT  = 90000;

  logic        MCLK;
  logic        SYS_RST;
  logic        POWER_GOOD;
  logic [15:0] IO_ADDR;
  logic        IO_WR;
  logic        IO_RD;
  logic [7:0]  IO_WDATA;
  logic [7:0]  IO_RDATA;
  logic        NMI_DISABLE;
  logic        IRQ;
  logic        SQW_OUT;
  logic [7:0]  rd;
  int          error_cnt = 0;
  int          compares  = 0;
  int          cycles    = 0;

  rtc_cmos_ram #(.CLK_HZ(SIM_CLK_HZ), .TB_HZ(SIM_TB_HZ)) dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .POWER_GOOD(POWER_GOOD), .IO_RDATA(IO_RDATA),
    .NMI_DISABLE(NMI_DISABLE), .IRQ(IRQ), .SQW_OUT(SQW_OUT)
  );

  rtc_host_model host (
    .MCLK(MCLK), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA)
  );

  // ----------------------------------------
  // Clock, limit and reporting
  // ----------------------------------------
  initial
  begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  always @(posedge MCLK)
  begin
    cycles <= cycles + 1;
    if (cycles == CYC_LIMIT)
    begin
      error_cnt++;
      $display("[FAIL] cycle limit expected below %0d seen %0d", CYC_LIMIT, cycles);
      test_done();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    #1;
    check("nmi mask", 8'h01, {7'h00, NMI_DISABLE});
    check("irq", 8'h00, {7'h00, IRQ});
    check("square wave", 8'h00, {7'h00, SQW_OUT});
    host.get_byte(8'h8a, rd);
    check("status a", 8'h26, rd);
    host.get_byte(8'h8b, rd);
    check("status b", 8'h02, rd);
    host.park(rd);
    check("status d powered", 8'h80, rd);
    @(posedge MCLK);
    POWER_GOOD <= 1'b0;
    host.park(rd);
    check("status d unpowered", 8'h00, rd);
    @(posedge MCLK);
    POWER_GOOD <= 1'b1;
    $display("reset test done");
  endtask

  task automatic t_ram;
    host.put_byte(8'h8e, 8'h5a);
    host.put_byte(8'hbf, 8'ha5);
    host.get_byte(8'h8e, rd);
    check("byte 0e", 8'h5a, rd);
    host.get_byte(8'hbf, rd);
    check("byte 3f", 8'ha5, rd);
    host.get_byte(8'hce, rd);
    check("index bit 6 ignored", 8'h5a, rd);
    host.put_byte(8'h8e, 8'h3c);
    host.io_cycle(rtc_pkg::DATA_PORT, 1'b0, 8'h00);
    @(posedge MCLK);
    #1;
    check("byte 0e direct reread", 8'h3c, IO_RDATA);
    host.put_byte(8'h0e, 8'h11);
    check("nmi unmasked", 8'h00, {7'h00, NMI_DISABLE});
    host.get_byte(8'h8e, rd);
    check("byte 0e rewritten", 8'h11, rd);
    check("nmi masked", 8'h01, {7'h00, NMI_DISABLE});
    host.put_byte(8'h8d, 8'h00);
    host.park(rd);
    check("status d read only", 8'h80, rd);
    $display("ram test done");
  endtask

  task automatic t_sqw;
    int   cnt;
    logic prev;
    host.put_byte(8'h8b, 8'h0a);
    cnt  = 0;
    prev = SQW_OUT;
    repeat (640)
    begin
      @(posedge MCLK);
      #1;
      if (SQW_OUT !== prev)
        cnt++;
      prev = SQW_OUT;
    end
    check("sqw toggles 19 to 21", 8'h01, {7'h00, cnt >= 19 && cnt <= 21});
    host.put_byte(8'h8b, 8'h02);
    repeat (4) @(posedge MCLK);
    #1;
    cnt  = 0;
    prev = SQW_OUT;
    repeat (128)
    begin
      @(posedge MCLK);
      #1;
      if (SQW_OUT !== prev)
        cnt++;
      prev = SQW_OUT;
    end
    check("sqw disabled toggles", 8'h00, cnt[7:0]);
    $display("square wave test done");
  endtask

  task automatic t_periodic;
    int n;
    host.get_byte(8'h8c, rd);
    host.put_byte(8'h8b, 8'h42);
    n = 0;
    while (IRQ !== 1'b1 && n < 200)
    begin
      @(posedge MCLK);
      #1;
      n++;
    end
    check("periodic irq", 8'h01, {7'h00, IRQ});
    host.get_byte(8'h8c, rd);
    check("status c periodic", 8'hc0, rd);
    check("irq after c read", 8'h00, {7'h00, IRQ});
    host.put_byte(8'h8b, 8'h02);
    $display("periodic test done");
  endtask

  task automatic t_update;
    int n;
    host.put_byte(8'h8b, 8'h82);
    host.put_byte(8'h80, 8'h59);
    host.put_byte(8'h82, 8'h59);
    host.put_byte(8'h84, 8'h91);
    host.put_byte(8'h86, 8'h07);
    host.put_byte(8'h87, 8'h31);
    host.put_byte(8'h88, 8'h12);
    host.put_byte(8'h89, 8'h99);
    host.put_byte(8'h81, 8'h00);
    host.put_byte(8'h83, 8'h00);
    host.put_byte(8'h85, 8'h12);
    host.get_byte(8'h8c, rd);
    host.put_byte(8'h8b, 8'h30);
    n  = 0;
    rd = 8'h00;
    while (rd[7] !== 1'b1 && n < 20000)
    begin
      host.get_byte(8'h8a, rd);
      n++;
    end
    check("update in progress", 8'h80, rd & 8'h80);
    n = 0;
    while (rd[7] !== 1'b0 && n < 100)
    begin
      host.get_byte(8'h8a, rd);
      n++;
    end
    check("alarm and update irq", 8'h01, {7'h00, IRQ});
    host.get_byte(8'h80, rd);
    check("seconds rolled", 8'h00, rd);
    host.get_byte(8'h82, rd);
    check("minutes bcd", 8'h00, rd);
    host.get_byte(8'h84, rd);
    check("hours 12h midnight", 8'h12, rd);
    host.get_byte(8'h86, rd);
    check("weekday wrapped", 8'h01, rd);
    host.get_byte(8'h89, rd);
    check("year wrapped", 8'h00, rd);
    host.get_byte(8'h8c, rd);
    check("status c all flags", 8'hf0, rd);
    check("irq cleared", 8'h00, {7'h00, IRQ});
    host.park(rd);
    $display("update test done");
  endtask

  initial
  begin
    SYS_RST    = 1'b1;
    POWER_GOOD = 1'b1;
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_ram();
    t_sqw();
    t_periodic();
    t_update();
    test_done();
  end
endmodule // test_rtc_cmos_ram
